/* tagl_panel_model.sv */
`timescale 1ns/1ps
module tagl_panel_model (
   input logic mclk,
   input logic stall,
   input logic outValid,
   input logic [1:0] outChannel,
   input logic [23:0] outSample,
   output logic outReady,
   output logic faderStb,
   output logic [1:0] faderTrack,
   output logic [7:0] faderDelta
);
   int rxCount = 0;
   logic [1:0] lastChan;
   logic [23:0] lastSample;
   initial begin
      outReady = 1'b0;
      faderStb = 1'b0;
      faderTrack = 2'h0;
      faderDelta = 8'h00;
   end
   always @(posedge mclk) begin
      if (outValid && outReady) begin
         rxCount++;
         lastChan = outChannel;
         lastSample = outSample;
      end
      outReady <= !stall;
   end
   // Level control move; lines show inverted data once released
   task automatic nudge(input logic [1:0] trk, input logic [7:0] d);
      @(posedge mclk);
      faderStb <= 1'b1;
      faderTrack <= trk;
      faderDelta <= d;
      @(posedge mclk);
      faderStb <= 1'b0;
      faderTrack <= ~trk;
      faderDelta <= ~d;
   endtask
endmodule

/* tagl_pkg.sv */
package tagl_pkg;
   // Register byte addresses on the Wishbone bus
   localparam logic [7:0] A_TRK_EN = 8'h00;
   localparam logic [7:0] A_CFG = 8'h04;
   localparam logic [7:0] A_MEDIA_SEL = 8'h08;
   localparam logic [7:0] A_ROUTE_CMD = 8'h0c;
   localparam logic [7:0] A_ROUTE0 = 8'h10;
   localparam logic [7:0] A_GAIN_CMD = 8'h1c;
   localparam logic [7:0] A_GAIN0 = 8'h20;
   localparam logic [7:0] A_THR = 8'h30;
   localparam logic [7:0] A_STATUS = 8'h34;

   // CFG field positions
   localparam int CFG_W = 7;
   localparam int CFG_ARM_ONLY = 0;
   localparam int CFG_LINK_LR = 1;
   localparam int CFG_LINK_AUX = 2;
   localparam int CFG_LIMON_LR = 3;
   localparam int CFG_LIMON_AUX = 4;
   localparam int CFG_LIMLINK_LR = 5;
   localparam int CFG_LIMLINK_AUX = 6;

   // Command and status field positions
   localparam int CMD_PRESS = 8;
   localparam int GCMD_DELTA_LSB = 8;
   localparam int GCMD_PRESS = 16;
   localparam int STAT_SHOW_LSB = 16;
   localparam int STAT_LIMACT_LSB = 20;
   localparam int STAT_FADER = 24;

   // Reset values
   localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
   localparam logic [23:0] THR_RST = 24'h7fffff;

   // Master gain in 0.1 dB steps
   localparam int GAIN_W = 11;
   localparam int NMASTER = 4;
   localparam logic signed [12:0] GAIN_MIN = -13'sd600;
   localparam logic signed [12:0] GAIN_MAX = 13'sd150;
   localparam logic [GAIN_W-1:0] GAIN_UNITY = 11'h000;
   localparam logic [11:0] GAIN_OFFSET = 12'h258;
   localparam logic [9:0] STEPS_PER_OCT = 10'h03c;
   localparam logic [17:0] OCT_RECIP_Q16 = 18'h00444;
   localparam int EXP_BIAS_SHIFT = 26;
   localparam logic [2:0] RED_MAX = 3'h7;

   // Indicator timing
   localparam int CLK_MHZ = 100;
   localparam int BLINK_HALF_MS = 250;
   localparam int DISP_HALF_MS = 1000;
   localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
   localparam int DISP_HALF_CYC = DISP_HALF_MS * 1000 * CLK_MHZ;
endpackage

/* tagl_track_arm.sv */
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// How it works
// - Armed means enabled and live input routed
// - Only armed tracks are ever recorded
// - No input or no media keeps unarmed
// - Indicator off, flashing, or steady per state
// - Arm-only option suppresses the flashing state
// - Write needs media selected, routed, armed
// - Reset routes every track to every media
// - Selector press inverts highlighted routing entry
// - Partial media alternates time and track count
// - Four master gains, -60 to +15 dB
// - Master gain applied to summed track signal
// - Linked pair adjusts both gains together
// - Selector press sets gain to unity
// - Each master track has own limiter
// - Limiter on/off applies to whole pair
// - Linked limiters share identical gain reduction
// - Indicators show engaged, active, joined limiters
// - Attached fader controller owns gain changes
module tagl_track_arm
   import tagl_pkg::*;
#(
   parameter int NTRK = 12,
   parameter int NMEDIA = 3,
   parameter int BLINK_HALF = BLINK_HALF_CYC,
   parameter int DISP_HALF = DISP_HALF_CYC
) (
   input logic mclk,
   input logic rst_b,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_we_i,
   input logic [7:0] wb_adr_i,
   input logic [3:0] wb_sel_i,
   input logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input logic [NTRK-1:0] trackInputLive,
   input logic faderAttached,
   input logic faderStb,
   input logic [1:0] faderTrack,
   input logic [7:0] faderDelta,
   input logic inValid,
   output logic inReady,
   input logic [1:0] inChannel,
   input logic [23:0] inSample,
   output logic outValid,
   input logic outReady,
   output logic [1:0] outChannel,
   output logic [23:0] outSample,
   output logic [NTRK-1:0] trackArmed,
   output logic [NTRK-1:0] trackLed,
   output logic [NMEDIA*NTRK-1:0] mediaWrite,
   output logic [NMEDIA-1:0] mediaShowCount,
   output logic [NMASTER-1:0] limiterEngaged,
   output logic [NMASTER-1:0] limiterActive,
   output logic [1:0] limiterJoined
);

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [NTRK-1:0] trkEn;
      logic [CFG_W-1:0] cfg;
      logic [NMEDIA-1:0] mediaSel;
      logic [NMEDIA-1:0][NTRK-1:0] route;
      logic [NMASTER-1:0][GAIN_W-1:0] gain;
      logic [23:0] thr;
      logic [NTRK-1:0] armed;
      logic [NTRK-1:0] led;
      logic [NMEDIA-1:0][NTRK-1:0] mWrite;
      logic [NMEDIA-1:0] showCount;
      logic [31:0] blinkCnt;
      logic blink;
      logic [31:0] dispCnt;
      logic dispPhase;
      logic inRdy;
      logic stV;
      logic [1:0] stCh;
      logic [23:0] stSmp;
      logic [1:0] bV;
      logic [1:0][1:0] bCh;
      logic [1:0][23:0] bSmp;
      logic [NMASTER-1:0][2:0] red;
      logic [NMASTER-1:0] limEng;
      logic [NMASTER-1:0] limAct;
      logic [1:0] limJoin;
   } tagl_state_s;

   tagl_state_s s;
   tagl_state_s n;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (dat & m);
   endfunction

   // Adds a signed step count and clamps to the legal gain range
   function automatic logic [GAIN_W-1:0] gainAdj(input logic [GAIN_W-1:0] g,
                                                 input logic [7:0] d);
      logic signed [12:0] t;
      t = 13'(signed'(g)) + 13'(signed'(d));
      if (t > GAIN_MAX) begin
         t = GAIN_MAX;
      end else if (t < GAIN_MIN) begin
         t = GAIN_MIN;
      end
      return t[GAIN_W-1:0];
   endfunction

   logic wr;
   logic [NTRK-1:0] anyRoute;
   logic [NTRK-1:0] armedNow;
   logic gCmd;
   logic [1:0] gTrk;
   logic [7:0] gDelta;
   logic gPress;
   logic [11:0] idxW;
   logic [9:0] idx;
   logic [9:0] ex;
   logic [9:0] fr;
   logic [17:0] coef;
   logic signed [42:0] prod;
   logic signed [55:0] wide;
   logic signed [55:0] gy;
   logic signed [23:0] g24;
   logic signed [23:0] ys;
   logic signed [24:0] mag;
   logic signed [24:0] thrS;
   logic [1:0] ch;
   logic [1:0] pr;
   logic limOn;
   logic limLk;
   logic [2:0] rEff;
   logic [2:0] rNew;
   logic [23:0] res;
   logic push;
   logic pop;
   logic [31:0] wcur;

   always_comb begin
      n = s;
      wr = 1'b0;
      wcur = 32'h0;
      // Single-cycle wait state: ack follows the first cycle of a request
      n.ack = wb_cyc_i & wb_stb_i & ~s.ack;
      wr = n.ack & wb_we_i;

      if (s.blinkCnt == 32'(BLINK_HALF - 1)) begin
         n.blinkCnt = 32'h0;
         n.blink = ~s.blink;
      end else begin
         n.blinkCnt = s.blinkCnt + 32'h1;
      end
      if (s.dispCnt == 32'(DISP_HALF - 1)) begin
         n.dispCnt = 32'h0;
         n.dispPhase = ~s.dispPhase;
      end else begin
         n.dispCnt = s.dispCnt + 32'h1;
      end

      // Arming and media decisions
      anyRoute = '0;
      for (int m = 0; m < NMEDIA; m++) begin
         anyRoute = anyRoute | s.route[m];
      end
      armedNow = s.trkEn & trackInputLive & anyRoute;
      n.armed = armedNow;
      n.led = armedNow | (s.trkEn & ~armedNow & {NTRK{s.blink & ~s.cfg[CFG_ARM_ONLY]}});
      for (int m = 0; m < NMEDIA; m++) begin
         n.mWrite[m] = armedNow & s.route[m] & {NTRK{s.mediaSel[m]}};
         n.showCount[m] = s.mediaSel[m] & (|(armedNow & ~s.route[m])) & s.dispPhase;
      end

      // Register writes
      if (wr) begin
         if (wb_adr_i == A_TRK_EN) begin
            wcur = merge(32'(s.trkEn), wb_dat_i, wb_sel_i);
            n.trkEn = wcur[NTRK-1:0];
         end else if (wb_adr_i == A_CFG) begin
            wcur = merge(32'(s.cfg), wb_dat_i, wb_sel_i);
            n.cfg = wcur[CFG_W-1:0];
         end else if (wb_adr_i == A_MEDIA_SEL) begin
            wcur = merge(32'(s.mediaSel), wb_dat_i, wb_sel_i);
            n.mediaSel = wcur[NMEDIA-1:0];
         end else if (wb_adr_i == A_THR) begin
            wcur = merge(32'(s.thr), wb_dat_i, wb_sel_i);
            n.thr = wcur[23:0];
         end else if (wb_adr_i == A_ROUTE_CMD && wb_sel_i[1] && wb_dat_i[CMD_PRESS]) begin
            for (int m = 0; m < NMEDIA; m++) begin
               for (int t = 0; t < NTRK; t++) begin
                  if (wb_dat_i[5:4] == 2'(m) && wb_dat_i[3:0] == 4'(t)) begin
                     n.route[m][t] = ~s.route[m][t];
                  end
               end
            end
         end
      end

      // Gain command source: the fader controller takes over when attached
      if (faderAttached) begin
         gCmd = faderStb;
         gTrk = faderTrack;
         gDelta = faderDelta;
         gPress = 1'b0;
      end else begin
         gCmd = wr && wb_adr_i == A_GAIN_CMD && (|wb_sel_i);
         gTrk = wb_dat_i[1:0];
         gDelta = wb_dat_i[GCMD_DELTA_LSB +: 8];
         gPress = wb_dat_i[GCMD_PRESS];
      end
      for (int t = 0; t < NMASTER; t++) begin
         // Pair linking stays under local control in both modes
         if (gCmd && (gTrk == 2'(t) ||
             (gTrk[1] == t[1] && (t[1] ? s.cfg[CFG_LINK_AUX] : s.cfg[CFG_LINK_LR])))) begin
            n.gain[t] = gPress ? GAIN_UNITY : gainAdj(s.gain[t], gDelta);
         end
      end

      // Master gain: 2^(steps/60) as exponent plus linear mantissa
      idxW = 12'(signed'(s.gain[s.stCh])) + GAIN_OFFSET;
      idx = idxW[9:0];
      ex = idx / STEPS_PER_OCT;
      fr = idx - 10'(ex * STEPS_PER_OCT);
      coef = 18'(({8'h00, fr} + 18'(STEPS_PER_OCT)) * OCT_RECIP_Q16);
      prod = signed'(s.stSmp) * signed'({1'b0, coef});
      wide = 56'(prod) <<< ex[3:0];
      gy = wide >>> EXP_BIAS_SHIFT;
      if (gy > 56'sh7fffff) begin
         g24 = 24'sh7fffff;
      end else if (gy < -56'sh800000) begin
         g24 = -24'sh800000;
      end else begin
         g24 = gy[23:0];
      end

      // Track limiter with shift-step gain reduction
      ch = s.stCh;
      pr = ch ^ 2'h1;
      limOn = ch[1] ? s.cfg[CFG_LIMON_AUX] : s.cfg[CFG_LIMON_LR];
      limLk = ch[1] ? s.cfg[CFG_LIMLINK_AUX] : s.cfg[CFG_LIMLINK_LR];
      rEff = (limLk && s.red[pr] > s.red[ch]) ? s.red[pr] : s.red[ch];
      ys = g24 >>> rEff;
      mag = ys[23] ? -25'(ys) : 25'(ys);
      thrS = signed'({1'b0, s.thr});
      rNew = rEff;
      res = ys;
      if (!limOn) begin
         rNew = 3'h0;
         res = g24;
      end else if (mag > thrS) begin
         rNew = (rEff == RED_MAX) ? RED_MAX : rEff + 3'h1;
         res = ys[23] ? 24'(-thrS) : s.thr;
      end else if (mag < (thrS >>> 1) && rEff != 3'h0) begin
         rNew = rEff - 3'h1;
      end

      // Stage, then two-entry output buffer
      pop = s.bV[0] & outReady;
      push = s.stV & ~s.bV[1];
      if (pop) begin
         n.bV = {1'b0, s.bV[1]};
         n.bCh[0] = s.bCh[1];
         n.bSmp[0] = s.bSmp[1];
      end
      if (push) begin
         n.red[ch] = rNew;
         if (limLk) begin
            n.red[pr] = rNew;
         end
         n.stV = 1'b0;
         if (!n.bV[0]) begin
            n.bV[0] = 1'b1;
            n.bCh[0] = ch;
            n.bSmp[0] = res;
         end else begin
            n.bV[1] = 1'b1;
            n.bCh[1] = ch;
            n.bSmp[1] = res;
         end
      end
      if (s.inRdy && inValid) begin
         n.stV = 1'b1;
         n.stCh = inChannel;
         n.stSmp = inSample;
      end
      n.inRdy = ~n.stV;

      for (int t = 0; t < NMASTER; t++) begin
         n.limEng[t] = t[1] ? s.cfg[CFG_LIMON_AUX] : s.cfg[CFG_LIMON_LR];
         n.limAct[t] = n.limEng[t] & (n.red[t] != 3'h0);
      end
      n.limJoin = {s.cfg[CFG_LIMON_AUX] & s.cfg[CFG_LIMLINK_AUX],
                   s.cfg[CFG_LIMON_LR] & s.cfg[CFG_LIMLINK_LR]};

      // Read data, zero for unmapped addresses
      n.rdat = 32'h0;
      if (wb_adr_i == A_TRK_EN) begin
         n.rdat = 32'(s.trkEn);
      end else if (wb_adr_i == A_CFG) begin
         n.rdat = 32'(s.cfg);
      end else if (wb_adr_i == A_MEDIA_SEL) begin
         n.rdat = 32'(s.mediaSel);
      end else if (wb_adr_i == A_THR) begin
         n.rdat = 32'(s.thr);
      end else if (wb_adr_i == A_STATUS) begin
         n.rdat = 32'(s.armed);
         n.rdat[STAT_SHOW_LSB +: NMEDIA] = s.showCount;
         n.rdat[STAT_LIMACT_LSB +: NMASTER] = s.limAct;
         n.rdat[STAT_FADER] = faderAttached;
      end
      for (int m = 0; m < NMEDIA; m++) begin
         if (wb_adr_i == A_ROUTE0 + 8'(4 * m)) begin
            n.rdat = 32'(s.route[m]);
         end
      end
      for (int t = 0; t < NMASTER; t++) begin
         if (wb_adr_i == A_GAIN0 + 8'(4 * t)) begin
            n.rdat = 32'(signed'(s.gain[t]));
         end
      end
      if (!n.ack) begin
         n.rdat = 32'h0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
         s.cfg <= CFG_RST;
         s.route <= '1;
         s.mediaSel <= '1;
         s.thr <= THR_RST;
         s.inRdy <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.rdat;
   assign inReady = s.inRdy;
   assign outValid = s.bV[0];
   assign outChannel = s.bCh[0];
   assign outSample = s.bSmp[0];
   assign trackArmed = s.armed;
   assign trackLed = s.led;
   assign mediaWrite = s.mWrite;
   assign mediaShowCount = s.showCount;
   assign limiterEngaged = s.limEng;
   assign limiterActive = s.limAct;
   assign limiterJoined = s.limJoin;

endmodule

/* tagl_track_arm_assertions.sv */
`timescale 1ns/1ps
module tagl_track_arm_assertions
   import tagl_pkg::*;
#(
   parameter int NTRK = 12,
   parameter int NMEDIA = 3
) (
   input logic mclk,
   input logic rst_b,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_ack_o,
   input logic inValid,
   input logic inReady,
   input logic outValid,
   input logic outReady,
   input logic [1:0] outChannel,
   input logic [23:0] outSample,
   input logic [NTRK-1:0] trackInputLive,
   input logic [NTRK-1:0] trackArmed,
   input logic [NTRK-1:0] trackLed,
   input logic [NMEDIA*NTRK-1:0] mediaWrite,
   input logic [NMASTER-1:0] limiterEngaged,
   input logic [NMASTER-1:0] limiterActive,
   input logic [1:0] limiterJoined
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   AST_IN_TAKE: assert property (inValid && inReady |=> !inReady)
      else $error("input not closed after take");
   AST_OUT_HOLD: assert property (outValid && !outReady |=>
      outValid && $stable(outSample) && $stable(outChannel))
      else $error("output word lost under stall");
   AST_ARM_LIVE: assert property ((trackArmed & ~($past(trackInputLive) |
      $past(trackInputLive, 2))) == '0)
      else $error("armed track without live input");
   AST_WRITE_ARMED: assert property ((mediaWrite & ~{NMEDIA{trackArmed}}) == '0)
      else $error("unarmed track written");
   AST_LED_ARMED: assert property ((trackArmed & ~trackLed) == '0)
      else $error("armed track indicator not lit");
   AST_LIM_PAIR: assert property (limiterEngaged[0] == limiterEngaged[1] &&
      limiterEngaged[2] == limiterEngaged[3])
      else $error("limiter pair split");
   AST_LIM_ACT: assert property ((limiterActive & ~limiterEngaged) == '0)
      else $error("active limiter not engaged");
   AST_LIM_LINK: assert property (limiterJoined[0] |-> limiterActive[0] == limiterActive[1])
      else $error("linked limiters differ");
   AST_LIM_LINK_AUX: assert property (limiterJoined[1] |->
      limiterActive[2] == limiterActive[3])
      else $error("linked aux limiters differ");
endmodule
bind tagl_track_arm tagl_track_arm_assertions #(.NTRK(NTRK), .NMEDIA(NMEDIA)) CHK (
   .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .inValid(inValid), .inReady(inReady), .outValid(outValid),
   .outReady(outReady), .outChannel(outChannel), .outSample(outSample),
   .trackInputLive(trackInputLive), .trackArmed(trackArmed), .trackLed(trackLed),
   .mediaWrite(mediaWrite), .limiterEngaged(limiterEngaged),
   .limiterActive(limiterActive), .limiterJoined(limiterJoined));

/* tb_track_arming_gain_limit.sv */
`timescale 1ns/1ps
module tb_track_arming_gain_limit;
   import tagl_pkg::*;
   logic mclk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, faderAttached, faderStb;
   logic inValid, inReady, outValid, outReady, stall;
   logic [1:0] inChannel, outChannel, faderTrack, limiterJoined;
   logic [3:0] wb_sel_i, limiterEngaged, limiterActive;
   logic [7:0] wb_adr_i, faderDelta;
   logic [23:0] inSample, outSample;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [11:0] trackInputLive, trackArmed, trackLed, seenOn, seenOff;
   logic [35:0] mediaWrite;
   logic [2:0] mediaShowCount, showOn, showOff;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   tagl_track_arm #(.BLINK_HALF(4), .DISP_HALF(8)) DUT (
      .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trackInputLive(trackInputLive),
      .faderAttached(faderAttached), .faderStb(faderStb), .faderTrack(faderTrack),
      .faderDelta(faderDelta), .inValid(inValid), .inReady(inReady), .inChannel(inChannel),
      .inSample(inSample), .outValid(outValid), .outReady(outReady),
      .outChannel(outChannel), .outSample(outSample), .trackArmed(trackArmed),
      .trackLed(trackLed), .mediaWrite(mediaWrite), .mediaShowCount(mediaShowCount),
      .limiterEngaged(limiterEngaged), .limiterActive(limiterActive),
      .limiterJoined(limiterJoined));
   tagl_panel_model PANEL (.mclk(mclk), .stall(stall), .outValid(outValid),
      .outChannel(outChannel), .outSample(outSample), .outReady(outReady),
      .faderStb(faderStb), .faderTrack(faderTrack), .faderDelta(faderDelta));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         summarize();
      end
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic near(input string nm, input logic [23:0] e, input logic [23:0] g);
      tests_run++;
      if ($isunknown(g) || g > e + 24'h400 || g + 24'h400 < e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge mclk);
      while (wb_ack_o !== 1'b1) @(posedge mclk);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic gcmd(input logic [1:0] t, input logic [7:0] d, input logic p);
      wb(1'b1, A_GAIN_CMD, {15'h0, p, d, 6'h0, t});
   endtask
   task automatic push(input logic [1:0] c, input logic [23:0] s);
      @(posedge mclk);
      inValid <= 1'b1;
      inChannel <= c;
      inSample <= s;
      @(posedge mclk);
      while (inReady !== 1'b1) @(posedge mclk);
      inValid <= 1'b0;
      inSample <= ~s;
   endtask
   // Let state settle, then record which indicator levels were seen
   task automatic watch(input int n);
      repeat (3) @(posedge mclk);
      seenOn = '0;
      seenOff = '0;
      showOn = '0;
      showOff = '0;
      repeat (n) begin
         @(posedge mclk);
         seenOn |= trackLed;
         seenOff |= ~trackLed;
         showOn |= mediaShowCount;
         showOff |= ~mediaShowCount;
      end
   endtask
   task automatic t_reset;
      rc(A_TRK_EN, 32'h0, "trkEn");
      rc(A_CFG, 32'h0, "cfg");
      rc(A_MEDIA_SEL, 32'h7, "mediaSel");
      for (int m = 0; m < 3; m++) rc(A_ROUTE0 + 8'(4 * m), 32'hfff, "route");
      rc(A_THR, 32'h7fffff, "thr");
      // Byte enables: only the low byte of the threshold may change
      wb_sel_i <= 4'h1;
      wb(1'b1, A_THR, 32'h12345678);
      wb_sel_i <= 4'hf;
      rc(A_THR, 32'h7fff78, "thrByte");
      rc(8'h3c, 32'h0, "unmapped");
      chk("ledRst", 32'h0, {20'h0, trackLed});
   endtask
   task automatic t_arm;
      trackInputLive <= 12'h00f;
      wb(1'b1, A_TRK_EN, 32'h0f5);
      watch(12);
      chk("armed", 32'h005, {20'h0, trackArmed});
      chk("ledOn", 32'h0f5, {20'h0, seenOn});
      chk("ledOff", 32'hffa, {20'h0, seenOff});
      for (int m = 0; m < 3; m++) chk("write", 32'h005, {20'h0, mediaWrite[12*m+:12]});
      wb(1'b1, A_CFG, 32'h1);
      watch(12);
      chk("ledArmOnly", 32'h005, {20'h0, seenOn});
      wb(1'b1, A_CFG, 32'h0);
   endtask
   task automatic t_route;
      wb(1'b1, A_ROUTE_CMD, 32'h100);
      rc(A_ROUTE0, 32'hffe, "route0");
      watch(24);
      chk("showOn", 32'h1, {29'h0, showOn});
      chk("showOff", 32'h7, {29'h0, showOff});
      chk("write0", 32'h004, {20'h0, mediaWrite[11:0]});
      wb(1'b1, A_ROUTE_CMD, 32'h110);
      wb(1'b1, A_ROUTE_CMD, 32'h120);
      watch(1);
      chk("noMedia", 32'h004, {20'h0, trackArmed});
      for (int m = 0; m < 3; m++) wb(1'b1, A_ROUTE_CMD, 32'h100 | 32'(m << 4));
      wb(1'b1, A_MEDIA_SEL, 32'h5);
      watch(1);
      chk("rearmed", 32'h005, {20'h0, trackArmed});
      chk("unselected", 32'h0, {20'h0, mediaWrite[23:12]});
      wb(1'b1, A_MEDIA_SEL, 32'h7);
   endtask
   task automatic t_gain;
      gcmd(2'h0, 8'h7f, 1'b0);
      gcmd(2'h0, 8'h7f, 1'b0);
      rc(A_GAIN0, 32'h96, "gainMax");
      gcmd(2'h0, 8'h00, 1'b1);
      rc(A_GAIN0, 32'h0, "unity");
      repeat (5) gcmd(2'h1, 8'h80, 1'b0);
      rc(A_GAIN0 + 8'h4, 32'hfffffda8, "gainMin");
      wb(1'b1, A_CFG, 32'h6);
      gcmd(2'h0, 8'h0a, 1'b0);
      rc(A_GAIN0, 32'ha, "linkL");
      rc(A_GAIN0 + 8'h4, 32'hfffffdb2, "linkR");
      gcmd(2'h3, 8'h05, 1'b0);
      rc(A_GAIN0 + 8'h8, 32'h5, "linkAux");
   endtask
   task automatic t_fader;
      faderAttached <= 1'b1;
      gcmd(2'h0, 8'h14, 1'b0);
      rc(A_GAIN0, 32'ha, "busLocked");
      PANEL.nudge(2'h0, 8'h14);
      rc(A_GAIN0, 32'h1e, "faderL");
      rc(A_GAIN0 + 8'h4, 32'hfffffdc6, "faderR");
      faderAttached <= 1'b0;
   endtask
   task automatic t_stream;
      for (int t = 0; t < 4; t++) gcmd(2'(t), 8'h00, 1'b1);
      stall <= 1'b1;
      push(2'h2, 24'h100000);
      push(2'h3, 24'h100000);
      push(2'h1, 24'h100000);
      repeat (4) @(posedge mclk);
      chk("inFull", 32'h0, {31'h0, inReady});
      stall <= 1'b0;
      while (PANEL.rxCount < 3) @(posedge mclk);
      chk("lastChan", 32'h1, {30'h0, PANEL.lastChan});
      near("unityOut", 24'h100000, PANEL.lastSample);
      wb(1'b1, A_THR, 32'h10000);
      wb(1'b1, A_CFG, 32'h2a);
      repeat (4) push(2'h0, 24'h200000);
      while (PANEL.rxCount < 7) @(posedge mclk);
      chk("engaged", 32'h3, {28'h0, limiterEngaged});
      chk("joined", 32'h1, {30'h0, limiterJoined});
      chk("active", 32'h3, {28'h0, limiterActive});
      near("limited", 24'h010000, PANEL.lastSample);
      rc(A_STATUS, 32'h00300005, "status");
      // Aux limiter alone, independent mode
      wb(1'b1, A_CFG, 32'h10);
      push(2'h2, 24'h200000);
      while (PANEL.rxCount < 8) @(posedge mclk);
      chk("engagedAux", 32'hc, {28'h0, limiterEngaged});
      chk("joinedOff", 32'h0, {30'h0, limiterJoined});
      chk("activeAux", 32'h4, {28'h0, limiterActive});
      near("limitedAux", 24'h010000, PANEL.lastSample);
   endtask
   // Reset in mid-run must bring back the default routing
   task automatic t_rerst;
      wb(1'b1, A_ROUTE_CMD, 32'h125);
      rc(A_ROUTE0 + 8'h8, 32'hfdf, "routeTog");
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      rc(A_ROUTE0 + 8'h8, 32'hfff, "routeRst");
      rc(A_CFG, 32'h0, "cfgRst");
      rc(A_GAIN0, 32'h0, "gainRst");
   endtask
   initial begin
      rst_b = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      trackInputLive = 12'h000;
      faderAttached = 1'b0;
      inValid = 1'b0;
      inChannel = 2'h0;
      inSample = 24'h0;
      stall = 1'b0;
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset();
      t_arm();
      t_route();
      t_gain();
      t_fader();
      t_stream();
      t_rerst();
      summarize();
   end
endmodule
